// *** rtl/ttr_router.sv ***
// Thermal trip event router: registers, trip flags and link message requests
`timescale 1ns/100ps
`include "ttr_map.svh"
module ttr_router (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// Register port
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [11:0]          reg_addr,
	input  wire logic [31:0]          reg_wdata,
	output logic      [31:0]          reg_rdata,
	// Global enables from the main error command registers
	input  wire logic                 global_error_command,
	input  wire logic                 global_smi_enable,
	input  wire logic                 global_sci_enable,
	// Internal sensor trip levels, Aux0 Hot Cat Aux1
	input  wire logic [3:0]           internal_trip,
	input  wire logic                 internal_throttle_en,
	// External sensor pins, active low, and mode straps from other registers
	input  wire logic                 first_external_sensor_input_n,
	input  wire logic                 second_external_sensor_input_n,
	input  wire logic                 fast_exit_en,
	input  wire logic                 aux0_remap_en,
	// Link message requests and acceptance
	output ttr_pkg::ttr_msg_type      msg_req,
	input  wire ttr_pkg::ttr_msg_type msg_ack,
	// Throttle outputs
	output logic                      throttle_active,
	output logic                      throttle_whole_device
);
	ttr_pkg::ttr_state_type s_q;
	ttr_pkg::ttr_state_type s_d;
	logic [3:0] ext_ev;
	logic [3:0] all_ev;
	logic [3:0] rise;
	logic [3:0] fall;
	logic       wr_aux;
	logic       wr_other;
	logic [1:0] ext_hot;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_d = s_q;
		ext_hot = ~s_q.ext_s2 & {2{s_q.ext_en}};
		// Map external inputs onto trip events
		ext_ev = 4'h0;
		if (ext_hot[0] && !aux0_remap_en)
		begin
			if (s_q.as0)
				ext_ev[`TTR_EV_HOT] = 1'b1;
			else
				ext_ev[`TTR_EV_CAT] = 1'b1;
		end
		if (ext_hot[0] && aux0_remap_en)
			ext_ev[`TTR_EV_AUX0] = 1'b1;
		if (ext_hot[1] && !fast_exit_en)
		begin
			if (s_q.as1)
				ext_ev[`TTR_EV_AUX0] = 1'b1;
			else
				ext_ev[`TTR_EV_HOT] = 1'b1;
		end
		all_ev = internal_trip | ext_ev;
		rise = all_ev & ~s_q.ev_prev;
		fall = ~all_ev & s_q.ev_prev;
		s_d.ev_prev = all_ev;
		s_d.ext_prev = ext_hot;
		s_d.ext_s1 = {second_external_sensor_input_n, first_external_sensor_input_n};
		s_d.ext_s2 = s_q.ext_s1;
		wr_aux = reg_wr && (reg_addr == `TTR_OFS_AUX);
		wr_other = reg_wr && !wr_aux && (reg_addr != `TTR_OFS_AUX_ALT);
		// Register writes
		if (reg_wr)
		begin
			case (reg_addr)
				`TTR_OFS_AUX:
				begin
					if (!s_q.aux_lock)
					begin
						s_d.aux1_target = reg_wdata[7:0];
						s_d.aux_lock = reg_wdata[`TTR_AUX_LOCK_BIT];
					end
				end
				`TTR_OFS_ERR:
					s_d.err_sel = reg_wdata[3:0];
				`TTR_OFS_SMI:
					s_d.smi_sel = reg_wdata[3:0];
				`TTR_OFS_SCI:
					s_d.sci_sel = reg_wdata[3:0];
				`TTR_OFS_INTR:
					s_d.intr_sel = reg_wdata[3:0];
				`TTR_OFS_EXT:
				begin
					if (reg_wdata[`TTR_EXT_EN_BIT])
						s_d.ext_en = 1'b1;
					if (!s_q.ext_en)
					begin
						s_d.throttle_kind_select = reg_wdata[`TTR_EXT_TTS_BIT];
						s_d.as1 = reg_wdata[`TTR_EXT_AS1_BIT];
						s_d.as0 = reg_wdata[`TTR_EXT_AS0_BIT];
					end
					s_d.route = reg_wdata[`TTR_EXT_ROUTE_BIT];
				end
				`TTR_OFS_STAT:
				begin
					s_d.int_up = s_q.int_up & ~reg_wdata[4:1];
					s_d.int_dn = s_q.int_dn & ~reg_wdata[9:6];
				end
				default:
				begin
				end
			endcase
		end
		// Unlock sequence: pattern at main, then alternate, then alternate
		if (s_q.aux_lock)
		begin
			if (wr_other)
				s_d.unl = ttr_pkg::UNL_IDLE;
			else if (reg_wr)
			begin
				case (s_q.unl)
					ttr_pkg::UNL_IDLE:
						s_d.unl = (wr_aux && reg_wdata == `TTR_UNLOCK_PAT) ?
							ttr_pkg::UNL_ONE : ttr_pkg::UNL_IDLE;
					ttr_pkg::UNL_ONE:
						s_d.unl = (!wr_aux && reg_wdata == `TTR_UNLOCK_PAT) ?
							ttr_pkg::UNL_TWO : ttr_pkg::UNL_IDLE;
					ttr_pkg::UNL_TWO:
					begin
						s_d.unl = ttr_pkg::UNL_IDLE;
						if (!wr_aux && reg_wdata == `TTR_UNLOCK_PAT)
							s_d.aux_lock = 1'b0;
					end
					default:
						s_d.unl = ttr_pkg::UNL_IDLE;
				endcase
			end
		end
		else
			s_d.unl = ttr_pkg::UNL_IDLE;
		// Sticky crossing flags; a new event wins over a clear
		if (s_q.route)
		begin
			s_d.ext_up = s_q.ext_up | (rise & ext_ev);
			s_d.ext_dn = s_q.ext_dn | (fall & s_q.ev_prev & ~internal_trip);
			s_d.int_up = s_d.int_up | (rise & internal_trip);
			s_d.int_dn = s_d.int_dn | (fall & ~ext_ev);
		end
		else
		begin
			s_d.int_up = s_d.int_up | rise;
			s_d.int_dn = s_d.int_dn | fall;
		end
		// Message requests: set per rising event, held until accepted
		s_d.req.err = (s_q.req.err & ~msg_ack.err)
			| (global_error_command && |(rise & s_q.err_sel));
		s_d.req.smi = (s_q.req.smi & ~msg_ack.smi)
			| (global_smi_enable && |(rise & s_q.smi_sel));
		s_d.req.sci = (s_q.req.sci & ~msg_ack.sci)
			| (global_sci_enable && |(rise & s_q.sci_sel));
		s_d.req.intr = (s_q.req.intr & ~msg_ack.intr) | |(rise & s_q.intr_sel);
		// Throttling from either source
		s_d.throttle = (internal_throttle_en && |internal_trip[2:1]) || (|ext_hot);
		s_d.throttle_dev = s_q.throttle_kind_select;
		// Read data, reserved bits zero
		s_d.rdata = `TTR_ZERO32;
		if (reg_rd)
		begin
			case (reg_addr)
				`TTR_OFS_AUX:
					s_d.rdata = {s_q.aux_lock, 23'h000000, s_q.aux1_target};
				`TTR_OFS_ERR:
					s_d.rdata = {28'h0000000, s_q.err_sel};
				`TTR_OFS_SMI:
					s_d.rdata = {28'h0000000, s_q.smi_sel};
				`TTR_OFS_SCI:
					s_d.rdata = {28'h0000000, s_q.sci_sel};
				`TTR_OFS_INTR:
					s_d.rdata = {28'h0000000, s_q.intr_sel};
				`TTR_OFS_EXT:
					s_d.rdata = {24'h000000, s_q.ext_en, s_q.throttle_kind_select, s_q.as1, s_q.as0,
						ext_hot[0], ext_hot[1] & ~fast_exit_en, 1'b0, s_q.route};
				`TTR_OFS_STAT:
					s_d.rdata = {22'h000000, s_q.int_dn, 1'b0, s_q.int_up, 1'b0};
				default:
					s_d.rdata = `TTR_ZERO32;
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// Outputs straight from flops
	assign reg_rdata = s_q.rdata;
	assign msg_req = s_q.req;
	assign throttle_active = s_q.throttle;
	assign throttle_whole_device = s_q.throttle_dev;
endmodule

// *** rtl/ttr_map.svh ***
// Register map, field positions and constants of the thermal trip event router
`ifndef TTR_MAP_SVH
`define TTR_MAP_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define TTR_OFS_AUX      12'hCEC
`define TTR_OFS_AUX_ALT  12'hCDC
`define TTR_OFS_ERR      12'hCF0
`define TTR_OFS_SMI      12'hCF1
`define TTR_OFS_SCI      12'hCF2
`define TTR_OFS_INTR     12'hCF3
`define TTR_OFS_EXT      12'hCFF
`define TTR_OFS_STAT     12'hCEA
// ----------------------------------------
// Fields and values
// ----------------------------------------
`define TTR_AUX_LOCK_BIT 31
`define TTR_UNLOCK_PAT   32'h04C1C202
`define TTR_SEL_MASK     8'h0F
`define TTR_EXT_EN_BIT   7
`define TTR_EXT_TTS_BIT  6
`define TTR_EXT_AS1_BIT  5
`define TTR_EXT_AS0_BIT  4
`define TTR_EXT_ROUTE_BIT 0
`define TTR_EV_AUX0      0
`define TTR_EV_HOT       1
`define TTR_EV_CAT       2
`define TTR_EV_AUX1      3
`define TTR_ZERO8        8'h00
`define TTR_ZERO32       32'h00000000
`endif

// *** rtl/ttr_pkg.sv ***
// Types of the thermal trip event router
package ttr_pkg;
	typedef enum logic [1:0] {UNL_IDLE, UNL_ONE, UNL_TWO} ttr_unl_type;
	typedef struct packed {
		logic        err;
		logic        smi;
		logic        sci;
		logic        intr;
	} ttr_msg_type;
	typedef struct packed {
		logic [7:0]  aux1_target;
		logic        aux_lock;
		ttr_unl_type unl;
		logic [3:0]  err_sel;
		logic [3:0]  smi_sel;
		logic [3:0]  sci_sel;
		logic [3:0]  intr_sel;
		logic        ext_en;
		logic        throttle_kind_select;
		logic        as1;
		logic        as0;
		logic        route;
		logic [1:0]  ext_s1;
		logic [1:0]  ext_s2;
		logic [1:0]  ext_prev;
		logic [3:0]  ev_prev;
		logic [3:0]  int_up;
		logic [3:0]  int_dn;
		logic [3:0]  ext_up;
		logic [3:0]  ext_dn;
		ttr_msg_type req;
		logic [31:0] rdata;
		logic        throttle;
		logic        throttle_dev;
	} ttr_state_type;
endpackage

// *** sim/ttr_hub.sv ***
// Link partner model that accepts message requests
`timescale 1ns/100ps
module ttr_hub (
	// Clock, reset and pace
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	input  wire logic                 slow,
	// Message link
	input  wire ttr_pkg::ttr_msg_type msg_req,
	output ttr_pkg::ttr_msg_type      msg_ack
);
	logic [2:0] wait_q;
	// Let a request wait one or five cycles, then accept it for one cycle
	always_ff @(posedge core_clk or negedge rst_n)
		if (!rst_n)
			{wait_q, msg_ack} <= 7'h00;
		else if (msg_req != 4'h0 && msg_ack == 4'h0 && wait_q < {slow, 2'h1})
			wait_q <= wait_q + 3'h1;
		else
			{wait_q, msg_ack} <= {3'h0, (msg_ack == 4'h0) ? msg_req : 4'h0};
endmodule

// *** sim/ttr_props.sv ***
// Port checker for the thermal trip event router
`timescale 1ns/100ps
module ttr_props (
	// Watched ports
	input wire logic                 core_clk,
	input wire logic                 rst_n,
	input wire logic                 reg_rd,
	input wire logic [11:0]          reg_addr,
	input wire logic [31:0]          reg_rdata,
	input wire logic                 global_error_command,
	input wire logic                 global_smi_enable,
	input wire logic                 global_sci_enable,
	input wire ttr_pkg::ttr_msg_type msg_req,
	input wire ttr_pkg::ttr_msg_type msg_ack
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Read data, reserved bits, gating and holding of requests
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("rdata not idle");
	a_sel_resv: assert property ($past(reg_rd) && $past(reg_addr[11:2]) == 10'h33C |-> reg_rdata[31:4] == 28'h0)
		else $error("select high bits set");
	a_aux_resv: assert property ($past(reg_rd) && $past(reg_addr) == 12'hCEC |-> reg_rdata[30:8] == 23'h0)
		else $error("aux reserved bits set");
	a_err_gate: assert property ($rose(msg_req.err) |-> $past(global_error_command))
		else $error("error request ungated");
	a_smi_gate: assert property (msg_req.smi && !$past(msg_req.smi) |-> $past(global_smi_enable))
		else $error("smi request ungated");
	a_sci_gate: assert property ($rose(msg_req.sci) |-> $past(global_sci_enable, 1))
		else $error("sci request ungated");
	a_req_hold: assert property (msg_req.intr && !msg_ack.intr |=> msg_req.intr)
		else $error("request dropped early");
	a_req_drop: assert property (msg_req.err && msg_ack.err |=> !msg_req.err)
		else $error("request kept after accept");
endmodule
bind ttr_router ttr_props u_props (.core_clk, .rst_n, .reg_rd, .reg_addr, .reg_rdata,
	.global_error_command, .global_smi_enable, .global_sci_enable, .msg_req, .msg_ack);

// *** sim/tb.sv ***
// Self-checking bench of the thermal trip event router
`timescale 1ns/100ps
module tb;
	logic                 core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic                 pin_n = 1'b1, slow = 1'b0, thr, thr_dev;
	logic [2:0]           glob = 3'h0;
	logic [3:0]           trip = 4'h0;
	logic [11:0]          reg_addr = 12'h000;
	logic [31:0]          reg_wdata = 32'h00000000, reg_rdata, rv;
	ttr_pkg::ttr_msg_type msg_req, msg_ack;
	int                   n_errors = 0, checks_done = 0;
	// Clock, router and link partner
	always #25 core_clk = ~core_clk;
	ttr_router dut (.core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.global_error_command(glob[2]), .global_smi_enable(glob[1]),
		.global_sci_enable(glob[0]), .internal_trip(trip), .internal_throttle_en(1'b0),
		.first_external_sensor_input_n(pin_n), .second_external_sensor_input_n(1'b1),
		.fast_exit_en(1'b0), .aux0_remap_en(1'b0), .msg_req, .msg_ack,
		.throttle_active(thr), .throttle_whole_device(thr_dev));
	ttr_hub hub (.core_clk, .rst_n, .slow, .msg_req, .msg_ack);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One register cycle; read data lands one edge after the strobe
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(rv, e);
	endtask
	// Select registers: zero after reset, only four live bits
	task automatic t_select();
		for (int k = 0; k < 4; k++)
		begin
			rc(12'(12'hCF0 + k), 32'h0);
			acc(1'b1, 12'(12'hCF0 + k), 32'hFF);
			rc(12'(12'hCF0 + k), 32'h0F);
			acc(1'b1, 12'(12'hCF0 + k), 32'h0);
		end
	endtask
	// Aux target locks, survives a broken unlock, frees after a whole one
	task automatic t_lock();
		rc(12'hCEC, 32'h0);
		acc(1'b1, 12'hCEC, 32'h55);
		acc(1'b1, 12'hCEC, 32'h80000055);
		for (int ab = 1; ab >= 0; ab--)
		begin
			acc(1'b1, 12'hCEC, 32'hAA);
			rc(12'hCEC, 32'h80000055);
			acc(1'b1, 12'hCEC, 32'h04C1C202);
			if (ab)
				acc(1'b1, 12'hCF0, 32'h0);
			repeat (2) acc(1'b1, 12'hCDC, 32'h04C1C202);
		end
		rc(12'hCEC, 32'h55);
		acc(1'b1, 12'hCEC, 32'hAA);
		rc(12'hCEC, 32'hAA);
	endtask
	// Every event and message kind, enables off then on, hub quick then slow
	task automatic t_msg();
		logic seen;
		for (int k = 0; k < 8; k++)
		begin
			acc(1'b1, 12'(12'hCF0 + k / 2), 32'(1 << (k / 2)));
			@(posedge core_clk);
			glob <= 3'(7 * (k % 2));
			slow <= 1'(k % 2);
			trip <= 4'(1 << (k / 2));
			seen = 1'b0;
			repeat (12)
			begin
				@(posedge core_clk);
				#1 seen = seen | msg_req[3 - k / 2];
			end
			chk(32'(seen), 32'(k % 2 == 1 || k / 2 == 3));
			chk(32'(msg_req), 32'h0);
			@(posedge core_clk);
			trip <= 4'h0;
			acc(1'b1, 12'(12'hCF0 + k / 2), 32'h0);
		end
	endtask
	// External enable sticks and locks the TTS, AS1 and AS0 fields; pin state reads back live
	task automatic t_ext();
		acc(1'b1, 12'hCFF, 32'hF1);
		acc(1'b1, 12'hCFF, 32'h00);
		chk(32'(thr), 32'h0);
		@(posedge core_clk);
		pin_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		rc(12'hCFF, 32'hF8);
		chk(32'(thr), 32'h1);
		chk(32'(thr_dev), 32'h1);
		rc(12'hCEA, 32'h3DE);
		acc(1'b1, 12'hCEA, 32'h3DE);
		rc(12'hCEA, 32'h0);
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Reset, then the scenarios in turn
	initial
	begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		t_select();
		t_lock();
		t_msg();
		t_ext();
		report_and_stop();
	end
endmodule
